// ==== design/ssm_regs.sv ====
// Contract
// (R1) Collision flag sets on a multimaster mode fault, else stays clear.
// (R2) Slave abort flag sets when select rises before a character completes.
// (R3) Every slave abort also sets the interrupt pending flag.
// (R4) Transmit active flag is one exactly while a transfer is in progress.
// (R5) As slave, select level bit mirrors the select input; meaningless as master.
// (R6) Software writes zeros to the two reserved status bits.
// (R7) Mode register: reserved top bits, readback bit, width field, select direction/value.
// (R8) With the port disabled every status bit returns to its reset value.
// (R9) Interrupt pending sets on transaction completion when enabled; write one clears.
// (R10) Width code zero means eight bits, codes one to seven that many.
// (R11) Readback bit set makes rate locations return live counter bytes.
// (R12) Collision and abort flags hold until the port is disabled or reset.
`include "ssm_map.svh"

module ssm_regs (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Register port
    input wire logic [11:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rd_data,
    // Interrupt
    output logic irq,
    // Serial pins
    input wire logic sck_pin,
    input wire logic ss_n_pin,
    output logic ss_n_out,
    output logic ss_n_oe,
    // Shift engine and rate generator
    input wire logic shift_busy,
    input wire logic shift_done,
    input wire logic shift_overrun,
    input wire logic [15:0] brg_count,
    // Configuration to the datapath
    output logic port_enable_bit,
    output logic master_mode,
    output logic clk_pol,
    output logic clk_phase,
    output logic open_drain,
    output logic [2:0] char_width_field,
    output logic [15:0] rate_reload
);

    ssm_pkg::ssm_regs_t q;
    ssm_pkg::ssm_regs_t d;

    logic trk_ss_level;
    logic trk_done;
    logic trk_abort;
    logic trk_busy;
    logic slave_en;

    // ------------------------------------------------------------------
    // Slave side tracker
    // ------------------------------------------------------------------
    assign slave_en = q.ctl[`SSM_CTL_EN] && !q.ctl[`SSM_CTL_MASTER];

    ssm_slave_track ssm_slave_track_i (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .slave_en(slave_en),
        .clk_pol(q.ctl[`SSM_CTL_POL]),
        .char_width(q.char_width_field),
        .sck_pin(sck_pin),
        .ss_n_pin(ss_n_pin),
        .ss_level(trk_ss_level),
        .char_done(trk_done),
        .char_abort(trk_abort),
        .busy(trk_busy)
    );

    // ------------------------------------------------------------------
    // Read data view of the status register
    // ------------------------------------------------------------------
    function automatic logic [7:0] stat_view(input ssm_pkg::ssm_regs_t s);
        logic [7:0] v;
        v = 8'h00;
        v[`SSM_ST_IRQ] = s.irq_pending;
        v[`SSM_ST_OVR] = s.overrun_flag;
        v[`SSM_ST_COL] = s.collision_flag;
        v[`SSM_ST_ABT] = s.slave_abort_flag;
        v[`SSM_ST_TRANSMIT_ACTIVE_FLAG] = s.transmit_active_flag;
        v[`SSM_ST_SELECT_INPUT_LEVEL] = s.select_input_level;
        stat_view = v;
    endfunction

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic en;
        logic master;
        logic wr_ctl;
        logic wr_stat;
        logic wr_mode;
        logic clr_irq;
        logic mode_fault;
        logic xact_done;
        logic [7:0] sticky;
        en = 1'b0;
        master = 1'b0;
        wr_ctl = 1'b0;
        wr_stat = 1'b0;
        wr_mode = 1'b0;
        clr_irq = 1'b0;
        mode_fault = 1'b0;
        xact_done = 1'b0;
        sticky = 8'h00;
        d = q;

        en = q.ctl[`SSM_CTL_EN];
        master = q.ctl[`SSM_CTL_MASTER];
        wr_ctl = wr_en && (addr == `SSM_ADDR_CTL);
        wr_stat = wr_en && (addr == `SSM_ADDR_STAT);
        wr_mode = wr_en && (addr == `SSM_ADDR_MODE);

        // --------------------------------------------------------------
        // Control, mode, mask and rate registers
        // --------------------------------------------------------------
        if (wr_ctl) begin
            d.ctl = wr_data;
        end
        if (wr_mode) begin
            // Top two bits are read only and never stored
            d.counter_readback_bit = wr_data[5]; // (R7)
            d.char_width_field = wr_data[4:2]; // (R7)
            d.select_pin_direction = wr_data[1]; // (R7)
            d.select_pin_value = wr_data[0]; // (R7)
        end
        if (wr_en && (addr == `SSM_ADDR_MASK)) begin
            d.irq_mask = wr_data;
        end
        if (wr_en && (addr == `SSM_ADDR_RATE_HI)) begin
            d.reload_hi = wr_data;
        end
        if (wr_en && (addr == `SSM_ADDR_RATE_LO)) begin
            d.reload_lo = wr_data;
        end

        // --------------------------------------------------------------
        // Events
        // --------------------------------------------------------------
        // Select driven low by another master while ours is an input
        mode_fault = en && master && !q.select_pin_direction && !trk_ss_level; // (R1)
        xact_done = en && ((master && shift_done) || (!master && trk_done)); // (R9)
        // Reserved status bits are ignored on write, so a nonzero write is harmless (R6)
        clr_irq = wr_stat && wr_data[`SSM_ST_IRQ];

        if (clr_irq) begin
            d.irq_pending = 1'b0; // (R9)
            d.ctl[`SSM_CTL_STR] = 1'b0;
        end
        // Set wins over a clear in the same cycle
        if (en && (xact_done || trk_abort || (wr_ctl && wr_data[`SSM_CTL_STR]))) begin
            d.irq_pending = 1'b1; // (R3)
        end
        if (mode_fault) begin
            d.collision_flag = 1'b1; // (R12)
        end
        if (en && !master && trk_abort) begin
            d.slave_abort_flag = 1'b1; // (R2)
        end
        if (en && shift_overrun) begin
            d.overrun_flag = 1'b1;
        end
        d.transmit_active_flag = en && (master ? shift_busy : trk_busy); // (R4)
        d.select_input_level = slave_en ? trk_ss_level : `SSM_RST_SELECT_INPUT_LEVEL; // (R5)

        // Disabled port holds every status bit at reset; the write that
        // disables wins against events from the same cycle
        if (!d.ctl[`SSM_CTL_EN]) begin
            d.irq_pending = 1'b0; // (R8)
            d.overrun_flag = 1'b0; // (R8)
            d.collision_flag = 1'b0; // (R8)
            d.slave_abort_flag = 1'b0; // (R8)
            d.transmit_active_flag = 1'b0; // (R8)
            d.select_input_level = `SSM_RST_SELECT_INPUT_LEVEL; // (R8)
        end

        // --------------------------------------------------------------
        // Interrupt output from next-state flags to save a cycle
        // --------------------------------------------------------------
        sticky = 8'h00;
        sticky[`SSM_ST_IRQ] = d.irq_pending;
        sticky[`SSM_ST_OVR] = d.overrun_flag;
        sticky[`SSM_ST_COL] = d.collision_flag;
        sticky[`SSM_ST_ABT] = d.slave_abort_flag;
        d.irq = |(sticky & d.irq_mask);

        // --------------------------------------------------------------
        // Select pin drive
        // --------------------------------------------------------------
        // In open-drain mode a high level is released rather than driven
        d.ss_n_out = d.select_pin_value;
        d.ss_n_oe = d.ctl[`SSM_CTL_EN] && d.select_pin_direction &&
                    !(d.ctl[`SSM_CTL_WOR] && d.select_pin_value);

        // --------------------------------------------------------------
        // Read data, valid only in the cycle after the strobe
        // --------------------------------------------------------------
        d.rd_data = 8'h00;
        if (rd_en) begin
            unique case (addr)
                `SSM_ADDR_CTL: begin
                    d.rd_data = q.ctl;
                end
                `SSM_ADDR_STAT: begin
                    d.rd_data = stat_view(q);
                end
                `SSM_ADDR_MODE: begin
                    d.rd_data = {2'b00, q.counter_readback_bit, q.char_width_field,
                                 q.select_pin_direction, q.select_pin_value}; // (R7)
                end
                `SSM_ADDR_MASK: begin
                    d.rd_data = q.irq_mask;
                end
                // Live counter bytes are not latched as a pair; a carry
                // between the two reads can tear the value
                `SSM_ADDR_RATE_HI: begin
                    d.rd_data = q.counter_readback_bit ? brg_count[15:8] : q.reload_hi; // (R11)
                end
                `SSM_ADDR_RATE_LO: begin
                    d.rd_data = q.counter_readback_bit ? brg_count[7:0] : q.reload_lo; // (R11)
                end
                default: begin
                    d.rd_data = 8'h00;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            q <= '{ctl: `SSM_RST_CTL,
                   counter_readback_bit: 1'b0,
                   char_width_field: 3'h0,
                   select_pin_direction: 1'b0,
                   select_pin_value: 1'b0,
                   irq_pending: 1'b0,
                   overrun_flag: 1'b0,
                   collision_flag: 1'b0,
                   slave_abort_flag: 1'b0,
                   transmit_active_flag: 1'b0,
                   select_input_level: `SSM_RST_SELECT_INPUT_LEVEL,
                   irq_mask: `SSM_RST_MASK,
                   reload_hi: `SSM_RST_RATE,
                   reload_lo: `SSM_RST_RATE,
                   rd_data: 8'h00,
                   irq: 1'b0,
                   ss_n_out: 1'b0,
                   ss_n_oe: 1'b0};
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all straight from the state register
    // ------------------------------------------------------------------
    assign rd_data = q.rd_data;
    assign irq = q.irq;
    assign ss_n_out = q.ss_n_out;
    assign ss_n_oe = q.ss_n_oe;
    assign port_enable_bit = q.ctl[`SSM_CTL_EN];
    assign master_mode = q.ctl[`SSM_CTL_MASTER];
    assign clk_pol = q.ctl[`SSM_CTL_POL];
    assign clk_phase = q.ctl[`SSM_CTL_PHASE];
    assign open_drain = q.ctl[`SSM_CTL_WOR];
    assign char_width_field = q.char_width_field;
    assign rate_reload = {q.reload_hi, q.reload_lo};

endmodule // ssm_regs

// ==== design/ssm_slave_track.sv ====
`include "ssm_map.svh"

module ssm_slave_track (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Configuration
    input wire logic slave_en,
    input wire logic clk_pol,
    input wire logic [2:0] char_width,
    // Pins
    input wire logic sck_pin,
    input wire logic ss_n_pin,
    // Results
    output logic ss_level,
    output logic char_done,
    output logic char_abort,
    output logic busy
);

    ssm_pkg::ssm_track_t q;
    ssm_pkg::ssm_track_t d;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic lead_edge;
        logic [3:0] nxt_cnt;
        lead_edge = 1'b0;
        nxt_cnt = 4'h0;
        d = q;
        // Only the second stage and its delayed copy are looked at by any logic
        d.ss_meta = ss_n_pin;
        d.ss_sync = q.ss_meta;
        d.sck_meta = sck_pin;
        d.sck_sync = q.sck_meta;
        d.sck_prev = q.sck_sync;
        d.ss_prev = q.ss_sync;
        d.done = 1'b0;
        d.abort = 1'b0;
        // Leading edge leaves the idle level, once per bit for either phase
        lead_edge = (q.sck_sync != q.sck_prev) && (q.sck_sync != clk_pol);
        nxt_cnt = q.bit_cnt + 4'h1;
        if (!slave_en) begin
            d.bit_cnt = 4'h0;
        end else if (q.ss_sync && !q.ss_prev) begin
            if (q.bit_cnt != 4'h0) begin
                d.abort = 1'b1; // (R2)
            end
            d.bit_cnt = 4'h0;
        end else if (!q.ss_sync && lead_edge) begin
            if (nxt_cnt == ssm_pkg::ssm_char_bits(char_width)) begin // (R10)
                d.done = 1'b1;
                d.bit_cnt = 4'h0;
            end else begin
                d.bit_cnt = nxt_cnt;
            end
        end
        d.busy = slave_en && (d.bit_cnt != 4'h0);
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            q <= '{ss_meta: 1'b1, ss_sync: 1'b1, sck_meta: 1'b0, sck_sync: 1'b0, sck_prev: 1'b0,
                   ss_prev: 1'b1, bit_cnt: 4'h0, done: 1'b0, abort: 1'b0, busy: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign ss_level = q.ss_sync;
    assign char_done = q.done;
    assign char_abort = q.abort;
    assign busy = q.busy;

endmodule // ssm_slave_track

// ==== pkg/ssm_map.svh ====
`ifndef SSM_MAP_SVH
`define SSM_MAP_SVH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define SSM_ADDR_CTL 12'hf61
`define SSM_ADDR_STAT 12'hf62
`define SSM_ADDR_MODE 12'hf63
`define SSM_ADDR_RATE_HI 12'hf66
`define SSM_ADDR_RATE_LO 12'hf67
`define SSM_ADDR_MASK 12'hf68

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define SSM_CTL_EN 0
`define SSM_CTL_MASTER 1
`define SSM_CTL_WOR 2
`define SSM_CTL_POL 3
`define SSM_CTL_PHASE 4
`define SSM_CTL_STR 6

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define SSM_ST_IRQ 7
`define SSM_ST_OVR 6
`define SSM_ST_COL 5
`define SSM_ST_ABT 4
`define SSM_ST_TRANSMIT_ACTIVE_FLAG 1
`define SSM_ST_SELECT_INPUT_LEVEL 0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SSM_RST_CTL 8'h00
`define SSM_RST_MODE 6'h00
`define SSM_RST_MASK 8'h00
`define SSM_RST_RATE 8'h00
`define SSM_RST_SELECT_INPUT_LEVEL 1'b1

`endif

// ==== pkg/ssm_pkg.sv ====
package ssm_pkg;

    // ------------------------------------------------------------------
    // Register block state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] ctl;
        logic counter_readback_bit;
        logic [2:0] char_width_field;
        logic select_pin_direction;
        logic select_pin_value;
        logic irq_pending;
        logic overrun_flag;
        logic collision_flag;
        logic slave_abort_flag;
        logic transmit_active_flag;
        logic select_input_level;
        logic [7:0] irq_mask;
        logic [7:0] reload_hi;
        logic [7:0] reload_lo;
        logic [7:0] rd_data;
        logic irq;
        logic ss_n_out;
        logic ss_n_oe;
    } ssm_regs_t;

    // ------------------------------------------------------------------
    // Slave transaction tracker state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic ss_meta;
        logic ss_sync;
        logic sck_meta;
        logic sck_sync;
        logic sck_prev;
        logic ss_prev;
        logic [3:0] bit_cnt;
        logic done;
        logic abort;
        logic busy;
    } ssm_track_t;

    // Character width code to bit count, code zero is a full byte
    function automatic logic [3:0] ssm_char_bits(input logic [2:0] code);
        ssm_char_bits = (code == 3'h0) ? 4'h8 : {1'b0, code};
    endfunction

endpackage

// ==== verif/spi_status_and_mode_regs_bench.sv ====
`include "ssm_map.svh"

module spi_status_and_mode_regs_bench;
    timeunit 1ns;
    timeprecision 100ps;

    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [7:0] wr_data = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic shift_busy = 1'b0;
    logic shift_done = 1'b0;
    logic shift_overrun = 1'b0;
    logic [15:0] brg_count = 16'h0000;
    logic go = 1'b0;
    logic [3:0] edges = 4'h0;
    logic [3:0] half = 4'h2;
    logic hold_sel = 1'b0;
    logic [7:0] rd_data;
    logic irq, sck_pin, ss_n_pin, ss_n_out, ss_n_oe, done;
    logic port_enable_bit, master_mode, clk_pol, clk_phase, open_drain;
    logic [2:0] char_width_field;
    logic [15:0] rate_reload;
    int miscompares = 0;
    int check_count = 0;

    always #5 ref_clk = ~ref_clk;

    ssm_regs ssm_regs_i (.ref_clk(ref_clk), .rst_b(rst_b), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .irq(irq), .sck_pin(sck_pin), .ss_n_pin(ss_n_pin),
        .ss_n_out(ss_n_out), .ss_n_oe(ss_n_oe), .shift_busy(shift_busy), .shift_done(shift_done),
        .shift_overrun(shift_overrun), .brg_count(brg_count), .port_enable_bit(port_enable_bit),
        .master_mode(master_mode), .clk_pol(clk_pol), .clk_phase(clk_phase), .open_drain(open_drain),
        .char_width_field(char_width_field), .rate_reload(rate_reload));

    ssm_far_master ssm_far_master_i (.ref_clk(ref_clk), .go(go), .edges(edges), .half(half),
        .hold_sel(hold_sel), .sck_pin(sck_pin), .ss_n_pin(ss_n_pin), .done(done));

    // ------------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------------
    task automatic final_report();
        if (miscompares == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input string name, input logic [11:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1;
        check(name, {8'h00, exp}, {8'h00, rd_data});
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // Pins pass two sync flops and the tracker before the status sees them
    task automatic frame(input logic [3:0] e, input logic [3:0] h);
        int k;
        @(posedge ref_clk);
        go <= 1'b1;
        edges <= e;
        half <= h;
        @(posedge ref_clk);
        go <= 1'b0;
        for (k = 0; k < 500 && done !== 1'b1; k++) begin
            @(posedge ref_clk);
        end
        if (k == 500) begin
            miscompares++;
            final_report();
        end
        wait_clk(8);
    endtask

    task automatic pulse_done();
        @(posedge ref_clk);
        shift_done <= 1'b1;
        @(posedge ref_clk);
        shift_done <= 1'b0;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        wait_clk(20);
        rst_b <= 1'b1;
        rd("status", `SSM_ADDR_STAT, 8'h01);
        rd("mode", `SSM_ADDR_MODE, 8'h00);
        rd("mask", `SSM_ADDR_MASK, 8'h00);
        wr(`SSM_ADDR_MODE, 8'hdf);
        rd("mode", `SSM_ADDR_MODE, 8'h1f);
        check("width", 16'h0007, {13'h0, char_width_field});
        wr(`SSM_ADDR_RATE_HI, 8'h12);
        wr(`SSM_ADDR_RATE_LO, 8'h34);
        brg_count <= 16'hbeef;
        rd("rate_hi", `SSM_ADDR_RATE_HI, 8'h12);
        rd("rate_lo", `SSM_ADDR_RATE_LO, 8'h34);
        check("reload", 16'h1234, rate_reload);
        wr(`SSM_ADDR_MODE, 8'h20);
        rd("rate_hi", `SSM_ADDR_RATE_HI, 8'hbe);
        rd("rate_lo", `SSM_ADDR_RATE_LO, 8'hef);
        rd("unmapped", 12'hf70, 8'h00);
        // Slave with three-bit characters
        wr(`SSM_ADDR_MODE, 8'h0c);
        wr(`SSM_ADDR_CTL, 8'h01);
        hold_sel <= 1'b1;
        wait_clk(8);
        rd("status", `SSM_ADDR_STAT, 8'h00);
        hold_sel <= 1'b0;
        wait_clk(8);
        rd("status", `SSM_ADDR_STAT, 8'h01);
        frame(4'h3, 4'h2);
        rd("status", `SSM_ADDR_STAT, 8'h81);
        wr(`SSM_ADDR_STAT, 8'h80);
        rd("status", `SSM_ADDR_STAT, 8'h01);
        // Code zero asks for eight bits, so three edges abort
        wr(`SSM_ADDR_MODE, 8'h00);
        frame(4'h3, 4'h4);
        rd("status", `SSM_ADDR_STAT, 8'h91);
        wr(`SSM_ADDR_MASK, 8'hf0);
        wait_clk(2);
        check("irq", 16'h0001, {15'h0, irq});
        wr(`SSM_ADDR_STAT, 8'h80);
        rd("status", `SSM_ADDR_STAT, 8'h11);
        check("irq", 16'h0001, {15'h0, irq});
        wr(`SSM_ADDR_CTL, 8'h00);
        rd("status", `SSM_ADDR_STAT, 8'h01);
        check("irq", 16'h0000, {15'h0, irq});
        // Master with a second master pulling select low
        wr(`SSM_ADDR_CTL, 8'h03);
        shift_busy <= 1'b1;
        hold_sel <= 1'b1;
        wait_clk(8);
        hold_sel <= 1'b0;
        pulse_done();
        wait_clk(4);
        rd("status", `SSM_ADDR_STAT, 8'ha3);
        shift_busy <= 1'b0;
        wait_clk(4);
        rd("status", `SSM_ADDR_STAT, 8'ha1);
        wr(`SSM_ADDR_CTL, 8'h00);
        rd("status", `SSM_ADDR_STAT, 8'h01);
        // Software interrupt request, cleared by writing one; only an enabled port takes it
        wr(`SSM_ADDR_CTL, 8'h01);
        wr(`SSM_ADDR_CTL, 8'h41);
        rd("status", `SSM_ADDR_STAT, 8'h81);
        check("irq", 16'h0001, {15'h0, irq});
        wr(`SSM_ADDR_STAT, 8'h80);
        rd("ctl", `SSM_ADDR_CTL, 8'h01);
        check("irq", 16'h0000, {15'h0, irq});
        wr(`SSM_ADDR_MODE, 8'h02);
        wait_clk(2);
        check("sel_pin", 16'h0002, {14'h0, ss_n_oe, ss_n_out});
        shift_overrun <= 1'b1;
        wait_clk(1);
        shift_overrun <= 1'b0;
        rd("status", `SSM_ADDR_STAT, 8'h41);
        final_report();
    end
endmodule // spi_status_and_mode_regs_bench

// ==== verif/ssm_far_master.sv ====
module ssm_far_master (
    // Clock
    input wire logic ref_clk,
    // Frame request
    input wire logic go,
    input wire logic [3:0] edges,
    input wire logic [3:0] half,
    input wire logic hold_sel,
    // Serial pins
    output logic sck_pin,
    output logic ss_n_pin,
    output logic done
);
    timeunit 1ns;
    timeprecision 100ps;

    logic frame_sel_b;

    // Serial clock idles low and stands still between frames
    initial begin
        sck_pin = 1'b0;
        frame_sel_b = 1'b1;
        done = 1'b0;
    end

    // A second master may pull select low with no clocks at all
    assign ss_n_pin = frame_sel_b & ~hold_sel;

    // A short edge count ends the frame early, as a real master may do
    always begin
        @(posedge ref_clk);
        if (go) begin
            frame_sel_b <= 1'b0;
            repeat (half) @(posedge ref_clk);
            for (int i = 0; i < edges; i++) begin
                sck_pin <= 1'b1;
                repeat (half) @(posedge ref_clk);
                sck_pin <= 1'b0;
                repeat (half) @(posedge ref_clk);
            end
            frame_sel_b <= 1'b1;
            done <= 1'b1;
            @(posedge ref_clk);
            done <= 1'b0;
        end
    end
endmodule // ssm_far_master

// ==== verif/ssm_regs_monitor.sv ====
`include "ssm_map.svh"

module ssm_regs_monitor (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Register port
    input wire logic [11:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] rd_data,
    input wire logic irq,
    // Pins and configuration
    input wire logic ss_n_out,
    input wire logic [15:0] brg_count,
    input wire logic port_enable_bit,
    input wire logic [2:0] char_width_field,
    input wire logic [15:0] rate_reload
);
    timeunit 1ns;
    timeprecision 100ps;

    // Shadows of the readback bit and the mask bits that gate the interrupt
    logic counter_readback_bit_q;
    logic [3:0] mask_q;

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            counter_readback_bit_q <= 1'b0;
            mask_q <= 4'h0;
        end else if (wr_en && addr == `SSM_ADDR_MODE) begin
            counter_readback_bit_q <= wr_data[5];
        end else if (wr_en && addr == `SSM_ADDR_MASK) begin
            mask_q <= wr_data[7:4];
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    rd_idle_a: assert property (!rd_en |=> rd_data == 8'h00)
        else $error("read data not zero outside a read");
    mode_rsvd_a: assert property (rd_en && addr == `SSM_ADDR_MODE |=> rd_data[7:6] == 2'b00)
        else $error("mode reserved bits read nonzero");
    stat_rsvd_a: assert property (rd_en && addr == `SSM_ADDR_STAT |=> rd_data[3:2] == 2'b00)
        else $error("status reserved bits read nonzero");
    width_field_a: assert property (wr_en && addr == `SSM_ADDR_MODE |=> char_width_field == $past(wr_data[4:2]))
        else $error("width field not taken from mode write");
    sel_value_a: assert property (wr_en && addr == `SSM_ADDR_MODE |=> ss_n_out == $past(wr_data[0]))
        else $error("select value not taken from mode write");
    disabled_stat_a: assert property (rd_en && addr == `SSM_ADDR_STAT && !port_enable_bit |=> rd_data == 8'h01)
        else $error("status not at reset value while disabled");
    disabled_irq_a: assert property (!port_enable_bit |-> !irq)
        else $error("interrupt high while disabled");
    live_count_a: assert property (rd_en && addr == `SSM_ADDR_RATE_HI && counter_readback_bit_q |=> rd_data == $past(brg_count[15:8]))
        else $error("readback did not return live counter");
    reload_read_a: assert property (rd_en && addr == `SSM_ADDR_RATE_LO && !counter_readback_bit_q |=> rd_data == $past(rate_reload[7:0]))
        else $error("reload low read wrong");
    irq_mask_a: assert property (irq |-> mask_q != 4'h0 || $past(mask_q) != 4'h0)
        else $error("interrupt high with all masks clear");
endmodule // ssm_regs_monitor

bind ssm_regs ssm_regs_monitor ssm_regs_monitor_i (.ref_clk(ref_clk), .rst_b(rst_b), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .irq(irq), .ss_n_out(ss_n_out),
    .brg_count(brg_count), .port_enable_bit(port_enable_bit), .char_width_field(char_width_field),
    .rate_reload(rate_reload));
